// >>> design/fsc_consts.vh
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH

// Parameter block byte indices of the module parameters.
`define FSC_PRM_IDX_MODE      4'hB
`define FSC_PRM_IDX_SUBST     4'hC

// Field positions inside the module parameter bytes and the output data byte.
`define FSC_MODE_LSB          0
`define FSC_MODE_MSB          1
`define FSC_SUBST_LSB         0
`define FSC_SUBST_MSB         3
`define FSC_OUT_LSB           0
`define FSC_OUT_MSB           3

// Fail-safe behaviour codes.
`define FSC_FS_ALL_LOW        2'h0
`define FSC_FS_ALL_HIGH       2'h1
`define FSC_FS_HOLD           2'h2
`define FSC_FS_SUBST          2'h3

// Reset values.
`define FSC_RST_MODE          8'h00
`define FSC_RST_SUBST         8'h00
`define FSC_RST_OUT           4'h0
`define FSC_RST_WD_PERIOD     16'h0001

// Fixed identification values.
`define FSC_PROFILE_CODE      16'hF600
`define FSC_PROFILE_TYPE      16'h0003
`define FSC_RECORD_VERSION    16'h0102
`define FSC_RECORD_MASK       16'h000E
`define FSC_REV_COUNTER       16'h0000

// Record geometry: every record is 54 bytes long.
`define FSC_REC_LEN           6'h36
`define FSC_REC1_BASE         8'h00
`define FSC_REC2_BASE         8'h36
`define FSC_REC3_BASE         8'h6C
`define FSC_DATE_END          8'h46
`define FSC_STORE_LEN         8'hA2
`define FSC_IM0_LAST_SHIFT    9'h1A8

// Preset characters.
`define FSC_CHAR_SPACE        8'h20
`define FSC_CHAR_ZERO         8'h00

// Status word bit positions.
`define FSC_ST_OUT_SHORT      0
`define FSC_ST_OUT_OVL        1
`define FSC_ST_ACT_SHORT      2
`define FSC_ST_ACT_UNDER      3
`define FSC_ST_MOD_OVL        4
`define FSC_ST_MOD_UNDER      5

`endif

// >>> design/fsc_output_safety_ctrl.v
`timescale 1ns/1ps
`include "fsc_consts.vh"
`default_nettype none

module fsc_output_safety_ctrl #(
   parameter          WD_WIDTH      = 16,
   parameter [15:0]   MAKER_CODE    = 16'h5A5A,   // Arbitrary value.
   parameter [159:0]  ORDER_NUMBER  = {20{8'h30}},
   parameter [127:0]  SERIAL_NUMBER = {16{8'h30}},
   parameter [15:0]   HW_REV        = 16'h0001,
   parameter [31:0]   SW_REV        = 32'h00000001
) (
   input  wire                core_clk,
   input  wire                reset_n,
   // Parameter bytes from the protocol engine.
   input  wire                prm_wr,
   input  wire [3:0]          prm_index,
   input  wire [7:0]          prm_data,
   input  wire                prm_done,
   input  wire                sync_enable,
   input  wire                freeze_enable,
   input  wire                alarm_disable,
   input  wire                wd_enable,
   input  wire [WD_WIDTH-1:0] wd_period,
   // Cyclic process data and commands.
   input  wire                comm_ok,
   input  wire                out_valid,
   input  wire                out_write,
   input  wire [7:0]          out_wdata,
   input  wire                in_read,
   input  wire                sync_cmd,
   input  wire                freeze_cmd,
   // Identification and maintenance records.
   input  wire                rec_rd,
   input  wire                rec_wr,
   input  wire [1:0]          rec_sel,
   input  wire [5:0]          rec_addr,
   input  wire [7:0]          rec_wdata,
   output reg                 rec_ack,
   output reg                 rec_err,
   output reg  [7:0]          rec_rdata,
   // Field pins.
   input  wire [7:0]          din_pins,
   input  wire                overtemp_pin,
   input  wire                sensor_surge_pin,
   input  wire                sensor_overload_pin,
   input  wire                actuator_surge_pin,
   input  wire                actuator_under_pin,
   input  wire                actuator_short_pin,
   input  wire                out_short_pin,
   input  wire                out_overload_pin,
   input  wire                module_under_pin,
   output reg  [3:0]          dout,
   output reg  [7:0]          in_data,
   output reg  [31:0]         status_word,
   output reg  [7:0]          diag_stored,
   output reg                 alarm_incoming,
   output reg                 alarm_outgoing,
   output reg                 group_error_led,
   output reg                 bus_fault_led,
   output reg                 failsafe
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.

   function [7:0] store_index;
      input [1:0] sel;
      input [5:0] addr;
      begin
         case (sel)
            2'h1:    store_index = `FSC_REC1_BASE + {2'h0, addr};
            2'h2:    store_index = `FSC_REC2_BASE + {2'h0, addr};
            default: store_index = `FSC_REC3_BASE + {2'h0, addr};
         endcase
      end
   endfunction

   function [7:0] store_preset;
      input [7:0] idx;
      begin
         if ((idx >= `FSC_DATE_END) && (idx < `FSC_REC3_BASE))
            store_preset = `FSC_CHAR_ZERO;
         else
            store_preset = `FSC_CHAR_SPACE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   reg [16:0] pin_meta;
   reg [16:0] pin_sync;
   wire [16:0] pin_raw = {module_under_pin, out_overload_pin, out_short_pin, actuator_short_pin,
                          actuator_under_pin, actuator_surge_pin, sensor_overload_pin,
                          sensor_surge_pin, overtemp_pin, din_pins};

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= 17'h00000;
         pin_sync <= 17'h00000;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   wire [7:0] din_s  = pin_sync[7:0];
   wire [7:0] diag_s = pin_sync[15:8];
   wire       mod_under_s = pin_sync[16];

   ////////////////////////////////////////////////////////////////////////
   // Module parameters.

   reg [7:0] output_failsafe_mode;
   reg [7:0] channel_substitute_levels;
   reg       sync_on;
   reg       freeze_on;
   reg       alarms_on;
   reg       wd_on;
   reg [WD_WIDTH-1:0] wd_limit;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         output_failsafe_mode      <= `FSC_RST_MODE;
         channel_substitute_levels <= `FSC_RST_SUBST;
         sync_on                   <= 1'b0;
         freeze_on                 <= 1'b0;
         alarms_on                 <= 1'b1;
         wd_on                     <= 1'b0;
         wd_limit                  <= `FSC_RST_WD_PERIOD;
      end else begin
         if (prm_wr && (prm_index == `FSC_PRM_IDX_MODE))
            output_failsafe_mode <= prm_data;
         if (prm_wr && (prm_index == `FSC_PRM_IDX_SUBST))
            channel_substitute_levels <= prm_data;
         if (prm_done) begin
            sync_on   <= sync_enable;
            freeze_on <= freeze_enable;
            alarms_on <= !alarm_disable;
            wd_on     <= wd_enable;
            wd_limit  <= (wd_period == {WD_WIDTH{1'b0}}) ? `FSC_RST_WD_PERIOD : wd_period;
         end
      end
   end

   wire [1:0] fs_code  = output_failsafe_mode[`FSC_MODE_MSB:`FSC_MODE_LSB];
   wire [3:0] fs_subst = channel_substitute_levels[`FSC_SUBST_MSB:`FSC_SUBST_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Watchdog. Only out_write touches it; in_read is deliberately ignored.

   reg                wd_running;
   reg                wd_expired;
   reg [WD_WIDTH-1:0] wd_count;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_running <= 1'b0;
         wd_expired <= 1'b0;
         wd_count   <= {WD_WIDTH{1'b0}};
      end else if (!wd_on) begin
         wd_running <= 1'b0;
         wd_expired <= 1'b0;
      end else if (out_write) begin
         wd_running <= 1'b1;
         wd_expired <= 1'b0;
         wd_count   <= wd_limit;
      end else if (wd_running) begin
         if (wd_count == {{(WD_WIDTH-1){1'b0}}, 1'b1}) begin
            wd_running <= 1'b0;
            wd_expired <= 1'b1;
         end
         wd_count <= wd_count - {{(WD_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output data path: staging for sync, active value, fail-safe select.

   reg  [3:0] out_stage;
   reg  [3:0] out_active;
   reg        have_data;
   reg  [3:0] next_dout;
   wire       fs_now = !comm_ok || !out_valid || !have_data || wd_expired;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_stage  <= `FSC_RST_OUT;
         out_active <= `FSC_RST_OUT;
         have_data  <= 1'b0;
      end else begin
         if (!comm_ok)
            have_data <= 1'b0;
         else if (out_write && out_valid)
            have_data <= 1'b1;
         if (out_write && out_valid)
            out_stage <= out_wdata[`FSC_OUT_MSB:`FSC_OUT_LSB];
         if (sync_on) begin
            if (sync_cmd)
               out_active <= (out_write && out_valid) ? out_wdata[`FSC_OUT_MSB:`FSC_OUT_LSB]
                                                      : out_stage;
         end else if (out_write && out_valid) begin
            out_active <= out_wdata[`FSC_OUT_MSB:`FSC_OUT_LSB];
         end
      end
   end

   always @* begin
      next_dout = out_active;
      if (fs_now) begin
         case (fs_code)
            `FSC_FS_ALL_LOW:  next_dout = 4'h0;
            `FSC_FS_ALL_HIGH: next_dout = 4'hF;
            `FSC_FS_HOLD:     next_dout = dout;
            `FSC_FS_SUBST:    next_dout = fs_subst;
            default:          next_dout = 4'h0;
         endcase
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dout          <= `FSC_RST_OUT;
         failsafe      <= 1'b1;
         bus_fault_led <= 1'b1;
      end else begin
         dout          <= next_dout;
         failsafe      <= fs_now;
         bus_fault_led <= wd_expired || !comm_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input data path and freeze.

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         in_data <= 8'h00;
      else if (!freeze_on || freeze_cmd)
         in_data <= din_s;
   end

   ////////////////////////////////////////////////////////////////////////
   // Diagnostics, alarms and status word.

   wire any_new   = |(diag_s & ~diag_stored);
   wire any_clear = |(~diag_s & diag_stored);

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         diag_stored     <= 8'h00;
         alarm_incoming  <= 1'b0;
         alarm_outgoing  <= 1'b0;
         group_error_led <= 1'b0;
         status_word     <= 32'h00000000;
      end else begin
         diag_stored     <= diag_s;
         alarm_incoming  <= alarms_on && any_new;
         alarm_outgoing  <= alarms_on && any_clear;
         group_error_led <= |diag_s;
         status_word     <= 32'h00000000;
         status_word[`FSC_ST_OUT_SHORT] <= diag_s[6];
         status_word[`FSC_ST_OUT_OVL]   <= diag_s[7];
         status_word[`FSC_ST_ACT_SHORT] <= diag_s[5];
         status_word[`FSC_ST_ACT_UNDER] <= diag_s[4];
         status_word[`FSC_ST_MOD_OVL]   <= diag_s[2];
         status_word[`FSC_ST_MOD_UNDER] <= mod_under_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Identification and maintenance records. Record 0 is built from
   // constants; records 1 to 3 share one flip-flop store of 162 bytes.

   wire [431:0] im0_vec = {MAKER_CODE, ORDER_NUMBER, SERIAL_NUMBER, HW_REV, SW_REV,
                           `FSC_REV_COUNTER, `FSC_PROFILE_CODE, `FSC_PROFILE_TYPE,
                           `FSC_RECORD_VERSION, `FSC_RECORD_MASK};
   wire [8:0]   im0_shift = `FSC_IM0_LAST_SHIFT - {rec_addr, 3'h0};
   wire [431:0] im0_sh    = im0_vec >> im0_shift;
   wire         addr_ok   = rec_addr < `FSC_REC_LEN;
   wire [7:0]   idx       = store_index(rec_sel, rec_addr);

   reg [7:0] im_store [0:161];
   integer   i;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (i = 0; i < 162; i = i + 1)
            im_store[i] <= store_preset(i[7:0]);
      end else if (rec_wr && addr_ok && (rec_sel != 2'h0)) begin
         im_store[idx] <= rec_wdata;
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rec_ack   <= 1'b0;
         rec_err   <= 1'b0;
         rec_rdata <= 8'h00;
      end else begin
         rec_ack <= rec_rd || rec_wr;
         rec_err <= (rec_rd || rec_wr) && (!addr_ok || (rec_wr && (rec_sel == 2'h0)));
         if (rec_rd) begin
            if (!addr_ok)
               rec_rdata <= 8'h00;
            else if (rec_sel == 2'h0)
               rec_rdata <= im0_sh[7:0];
            else
               rec_rdata <= im_store[idx];
         end
      end
   end

endmodule // fsc_output_safety_ctrl

`default_nettype wire

// >>> tb/fsc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_master_model (
   input  wire logic       core_clk,
   input  wire logic       run,
   input  wire logic [4:0] gap,
   input  wire logic [7:0] data,
   output logic            out_write,
   output logic [7:0]      out_wdata
);
   logic [4:0] cnt;
   initial begin
      out_write = 1'b0;
      out_wdata = 8'h00;
      cnt = 5'h00;
   end
   // Cyclic writer; stopping it with run low is the deliberate fault case.
   always @(posedge core_clk) begin
      out_write <= 1'b0;
      out_wdata <= ~out_wdata;
      if (run && cnt == 5'h00) begin
         out_write <= 1'b1;
         out_wdata <= data;
      end
      cnt <= (run && cnt != gap) ? cnt + 5'h01 : 5'h00;
   end
endmodule // fsc_master_model
`default_nettype wire

// >>> tb/fsc_output_safety_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_output_safety_ctrl_props (
   input wire logic       core_clk,
   input wire logic       reset_n,
   input wire logic       prm_wr,
   input wire logic [3:0] prm_index,
   input wire logic [7:0] prm_data,
   input wire logic       comm_ok,
   input wire logic       out_valid,
   input wire logic       rec_rd,
   input wire logic       rec_wr,
   input wire logic [1:0] rec_sel,
   input wire logic [5:0] rec_addr,
   input wire logic       rec_ack,
   input wire logic       rec_err,
   input wire logic [7:0] rec_rdata,
   input wire logic [3:0] dout,
   input wire logic [7:0] diag_stored,
   input wire logic       alarm_incoming,
   input wire logic       alarm_outgoing,
   input wire logic       group_error_led,
   input wire logic       bus_fault_led,
   input wire logic       failsafe
);
   logic [1:0] mode_h;
   logic [3:0] subst_h;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   // Shadow of the mode bytes, so fail-safe patterns can be judged from the ports alone.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_h  <= 2'h0;
         subst_h <= 4'h0;
      end else if (prm_wr) begin
         if (prm_index == 4'hB) mode_h <= prm_data[1:0];
         if (prm_index == 4'hC) subst_h <= prm_data[3:0];
      end
   end
   property p_grp; group_error_led == (diag_stored != 8'h00); endproperty
   a_grp: assert property (p_grp) else $error("group led wrong");
   property p_inc; alarm_incoming |-> (diag_stored & ~$past(diag_stored)) != 8'h00; endproperty
   a_inc: assert property (p_inc) else $error("incoming alarm without new entry");
   property p_outg; alarm_outgoing |-> ($past(diag_stored) & ~diag_stored) != 8'h00; endproperty
   a_outg: assert property (p_outg) else $error("outgoing alarm without cleared entry");
   property p_bf; !comm_ok |-> ##[1:2] bus_fault_led; endproperty
   a_bf: assert property (p_bf) else $error("bus fault led dark on lost link");
   property p_fs; (!comm_ok || !out_valid) |-> ##[1:2] failsafe; endproperty
   a_fs: assert property (p_fs) else $error("no fail-safe on lost data");
   property p_low; failsafe && $past(mode_h) == 2'h0 |-> dout == 4'h0; endproperty
   a_low: assert property (p_low) else $error("fail-safe low wrong");
   property p_high; failsafe && $past(mode_h) == 2'h1 |-> dout == 4'hF; endproperty
   a_high: assert property (p_high) else $error("fail-safe high wrong");
   property p_hold; failsafe && $past(mode_h) == 2'h2 |-> dout == $past(dout); endproperty
   a_hold: assert property (p_hold) else $error("fail-safe hold wrong");
   property p_subst; failsafe && $past(mode_h) == 2'h3 |-> dout == $past(subst_h); endproperty
   a_subst: assert property (p_subst) else $error("substitute pattern wrong");
   property p_ro; rec_wr && rec_sel == 2'h0 |=> rec_ack && rec_err; endproperty
   a_ro: assert property (p_ro) else $error("identity record accepted a write");
   property p_bad; rec_rd && rec_addr > 6'h35 |=> rec_err && rec_rdata == 8'h00; endproperty
   a_bad: assert property (p_bad) else $error("read past record end accepted");
   c_inc: cover property (alarm_incoming);
   c_hold: cover property (failsafe && $past(mode_h) == 2'h2);
   c_err: cover property (rec_err);
endmodule // fsc_output_safety_ctrl_props
bind fsc_output_safety_ctrl fsc_output_safety_ctrl_props u_props (
   .core_clk, .reset_n, .prm_wr, .prm_index, .prm_data, .comm_ok, .out_valid, .rec_rd, .rec_wr,
   .rec_sel, .rec_addr, .rec_ack, .rec_err, .rec_rdata, .dout, .diag_stored, .alarm_incoming,
   .alarm_outgoing, .group_error_led, .bus_fault_led, .failsafe);
`default_nettype wire

// >>> tb/test_fieldbus_output_safety_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_output_safety_ctrl;
   logic        core_clk, reset_n, prm_wr, prm_done, sync_enable, freeze_enable, alarm_disable;
   logic        wd_enable, comm_ok, out_valid, out_write, in_read, sync_cmd, freeze_cmd, run;
   logic        rec_rd, rec_wr, rec_ack, rec_err, alarm_incoming, alarm_outgoing;
   logic        group_error_led, bus_fault_led, failsafe;
   logic [1:0]  rec_sel;
   logic [3:0]  prm_index, dout;
   logic [4:0]  gap;
   logic [5:0]  rec_addr;
   logic [7:0]  prm_data, out_wdata, rec_wdata, rec_rdata, din_pins, in_data, diag_stored;
   logic [7:0]  data, d, s, p, q;
   logic [8:0]  pv;
   logic [15:0] wd_period;
   logic [31:0] status_word;
   int          errors, samples_checked, seed, n_in, n_out, n;
   localparam logic [79:0] IDENT = 80'h0000_F600_0003_0102_000E;

   fsc_output_safety_ctrl u_dut (
      .core_clk, .reset_n, .prm_wr, .prm_index, .prm_data, .prm_done, .sync_enable, .freeze_enable,
      .alarm_disable, .wd_enable, .wd_period, .comm_ok, .out_valid, .out_write, .out_wdata, .in_read,
      .sync_cmd, .freeze_cmd, .rec_rd, .rec_wr, .rec_sel, .rec_addr, .rec_wdata, .rec_ack, .rec_err,
      .rec_rdata, .din_pins, .overtemp_pin(pv[0]), .sensor_surge_pin(pv[1]), .sensor_overload_pin(pv[2]),
      .actuator_surge_pin(pv[3]), .actuator_under_pin(pv[4]), .actuator_short_pin(pv[5]),
      .out_short_pin(pv[6]), .out_overload_pin(pv[7]), .module_under_pin(pv[8]), .dout, .in_data,
      .status_word, .diag_stored, .alarm_incoming, .alarm_outgoing, .group_error_led, .bus_fault_led,
      .failsafe);
   fsc_master_model u_master (.core_clk, .run, .gap, .data, .out_write, .out_wdata);

   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      if (alarm_incoming === 1'b1) n_in++;
      if (alarm_outgoing === 1'b1) n_out++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic prm(input logic [3:0] idx, input logic [7:0] v);
      {prm_index, prm_data, prm_wr} = {idx, v, 1'b1};
      tick(1);
      prm_wr = 1'b0;
      tick(1);
   endtask
   task automatic cfg(input logic sy, input logic fr, input logic ad);
      {sync_enable, freeze_enable, alarm_disable, prm_done} = {sy, fr, ad, 1'b1};
      tick(1);
      prm_done = 1'b0;
   endtask
   task automatic rec(input logic w, input logic [1:0] sl, input logic [5:0] a, input logic [7:0] wd,
                      input logic ee, input logic [7:0] ed);
      {rec_rd, rec_wr, rec_sel, rec_addr, rec_wdata} = {!w, w, sl, a, wd};
      tick(1);
      {rec_rd, rec_wr} = 2'b00;
      check("rec_ack", rec_ack, 1'b1);
      check("rec_err", rec_err, ee);
      if (!w) check("rec_rdata", rec_rdata, ed);
      tick(1);
   endtask
   function automatic logic [3:0] fsv(input logic [1:0] m, input logic [3:0] sv, input logic [3:0] h);
      case (m)
         2'h0: return 4'h0;
         2'h1: return 4'hF;
         2'h2: return h;
         default: return sv;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // Generous against the roughly 400 cycles the sequence needs.
   initial begin
      #200000;
      errors++;
      conclude;
   end
   initial begin
      {reset_n, prm_wr, prm_done, sync_enable, freeze_enable, alarm_disable, comm_ok, out_valid} = 8'h00;
      {in_read, sync_cmd, freeze_cmd, rec_rd, rec_wr, run, wd_enable} = 7'h01;
      {rec_sel, prm_index, rec_addr, prm_data, rec_wdata, din_pins, data, pv} = 53'h0;
      {wd_period, gap, seed} = {16'h0008, 5'h03, 32'h7910};
      {errors, samples_checked, n_in, n_out} = 128'h0;
      tick(6);
      reset_n = 1'b1;
      check("dout", dout, 4'h0);
      check("failsafe", failsafe, 1'b1);
      cfg(1'b0, 1'b0, 1'b0);
      n = $random(seed);
      d = n[7:0];
      data = d;
      {comm_ok, out_valid, run, in_read} = 4'hF;
      tick(6);
      check("dout", dout, d[3:0]);
      check("failsafe", failsafe, 1'b0);
      tick(40);
      check("bus_fault_led", bus_fault_led, 1'b0);
      // Reads stay asserted while writes stop, so only the last write may start the count.
      do @(posedge core_clk); while (out_write !== 1'b1);
      @(negedge core_clk);
      run = 1'b0;
      n = 0;
      while (bus_fault_led !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1 n++;
      end
      @(negedge core_clk);
      check("watchdog span", n, 32'h9);
      check("failsafe", failsafe, 1'b1);
      tick(20);
      check("bus_fault_led", bus_fault_led, 1'b1);
      {run, in_read} = 2'b10;
      tick(6);
      check("bus_fault_led", bus_fault_led, 1'b0);
      for (int i = 0; i < 4; i++) begin
         n = $random(seed);
         {s, d} = n[15:0];
         prm(4'hB, {d[7:2], i[1:0]});
         prm(4'hC, s);
         prm(4'hA, 8'hFF);
         data = d;
         tick(8);
         check("dout", dout, d[3:0]);
         comm_ok = 1'b0;
         tick(4);
         check("dout", dout, fsv(i[1:0], s[3:0], d[3:0]));
         comm_ok = 1'b1;
         tick(8);
      end
      out_valid = 1'b0;
      tick(4);
      check("failsafe", failsafe, 1'b1);
      out_valid = 1'b1;
      tick(8);
      cfg(1'b1, 1'b0, 1'b0);
      s = d ^ 8'h0F;
      data = s;
      tick(12);
      check("dout", dout, d[3:0]);
      sync_cmd = 1'b1;
      tick(1);
      sync_cmd = 1'b0;
      tick(3);
      check("dout", dout, s[3:0]);
      cfg(1'b0, 1'b0, 1'b0);
      n = $random(seed);
      p = n[7:0];
      q = ~p;
      din_pins = p;
      tick(5);
      check("in_data", in_data, p);
      cfg(1'b0, 1'b1, 1'b0);
      din_pins = q;
      tick(6);
      check("in_data", in_data, p);
      freeze_cmd = 1'b1;
      tick(1);
      freeze_cmd = 1'b0;
      tick(3);
      check("in_data", in_data, q);
      for (int i = 0; i < 9; i++) begin
         pv = 9'h001 << i;
         tick(5);
         check("diag_stored", diag_stored, pv[7:0]);
         check("group_error_led", group_error_led, |pv[7:0]);
         check("status_word", status_word, {26'h0, pv[8], pv[2], pv[4], pv[5], pv[7], pv[6]});
         pv = 9'h000;
         tick(5);
         check("group_error_led", group_error_led, 1'b0);
      end
      check("incoming alarms", n_in, 32'h8);
      check("outgoing alarms", n_out, 32'h8);
      cfg(1'b0, 1'b0, 1'b1);
      pv = 9'h0FF;
      tick(5);
      pv = 9'h000;
      tick(5);
      check("incoming alarms", n_in, 32'h8);
      check("outgoing alarms", n_out, 32'h8);
      n = $random(seed);
      s = n[7:0];
      rec(1'b1, 2'h0, 6'h2E, s, 1'b1, 8'h00);
      for (int k = 0; k < 10; k++) rec(1'b0, 2'h0, 6'h2C + k[5:0], 8'h00, 1'b0, IDENT[79 - 8 * k -: 8]);
      rec(1'b0, 2'h1, 6'h00, 8'h00, 1'b0, 8'h20);
      rec(1'b0, 2'h1, 6'h35, 8'h00, 1'b0, 8'h20);
      rec(1'b0, 2'h2, 6'h0F, 8'h00, 1'b0, 8'h20);
      rec(1'b0, 2'h2, 6'h10, 8'h00, 1'b0, 8'h00);
      rec(1'b0, 2'h2, 6'h35, 8'h00, 1'b0, 8'h00);
      rec(1'b0, 2'h3, 6'h35, 8'h00, 1'b0, 8'h20);
      rec(1'b1, 2'h3, 6'h35, s, 1'b0, 8'h00);
      rec(1'b1, 2'h1, 6'h1F, q, 1'b0, 8'h00);
      rec(1'b0, 2'h3, 6'h35, 8'h00, 1'b0, s);
      rec(1'b0, 2'h1, 6'h1F, 8'h00, 1'b0, q);
      rec(1'b0, 2'h1, 6'h36, 8'h00, 1'b1, 8'h00);
      // A reset in mid-run must bring the written bytes back to their presets.
      reset_n = 1'b0;
      tick(2);
      check("bus_fault_led", bus_fault_led, 1'b1);
      reset_n = 1'b1;
      check("failsafe", failsafe, 1'b1);
      check("dout", dout, 4'h0);
      tick(1);
      rec(1'b0, 2'h3, 6'h35, 8'h00, 1'b0, 8'h20);
      rec(1'b0, 2'h1, 6'h1F, 8'h00, 1'b0, 8'h20);
      conclude;
   end
endmodule // test_fieldbus_output_safety_ctrl
`default_nettype wire
